// File: design/tmtwo_fall_detect.sv
// Synchroniser and falling-edge detector for one pin input.
// Assumes the pin is asynchronous to pclk; adds two cycles of latency.
`timescale 1ns/10ps
module tmtwo_fall_detect (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic pin,
	output logic fall
);
	logic sync_first;
	logic sync_second;
	logic sync_last;
	// Idle high so reset never fakes an edge
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sync_first <= 1'b1;
			sync_second <= 1'b1;
			sync_last <= 1'b1;
		end else begin
			sync_first <= pin;
			sync_second <= sync_first;
			sync_last <= sync_second;
		end
	end
	assign fall = sync_last & ~sync_second;
endmodule : tmtwo_fall_detect

// File: design/tmtwo_pkg.sv
// Constants for the third timer/counter block: register map, field positions, timing.
// Assumes a 10 MHz APB clock; one oscillator period equals one pclk period.
package tmtwo_pkg;
	// Register byte addresses (one aligned word each)
	localparam logic [7:0] ADDR_CONTROL = 8'h00;
	localparam logic [7:0] ADDR_COUNT_LOW = 8'h04;
	localparam logic [7:0] ADDR_COUNT_HIGH = 8'h08;
	localparam logic [7:0] ADDR_RELOAD_LOW = 8'h0C;
	localparam logic [7:0] ADDR_RELOAD_HIGH = 8'h10;
	localparam logic [7:0] ADDR_SERIAL_TICK = 8'h14;
	// Control register field positions
	localparam int BIT_OVF = 7;
	localparam int BIT_EXF = 6;
	localparam int BIT_RCLK = 5;
	localparam int BIT_TX_SEL = 4;
	localparam int BIT_EXEN = 3;
	localparam int BIT_RUN = 2;
	localparam int BIT_CT = 1;
	localparam int BIT_CPRL = 0;
	// Reset values
	localparam logic [7:0] CONTROL_RESET = 8'h00;
	localparam logic [15:0] COUNT_RESET = 16'h0000;
	localparam logic [15:0] RELOAD_RESET = 16'h0000;
	// Internal timer tick: twelve oscillator periods
	localparam int OSC_PER_TICK = 12;
	localparam logic [3:0] TICK_LAST = 4'(OSC_PER_TICK - 1);
	localparam logic [31:0] UNMAPPED_READ = 32'h0000_0000;
	typedef enum logic [3:0] {
		TMTWO_OFF = 4'h1,
		TMTWO_RELOAD = 4'h2,
		TMTWO_CAPTURE = 4'h4,
		TMTWO_BAUD = 4'h8
	} tmtwo_mode_t;
endpackage : tmtwo_pkg

// File: design/tmtwo_prescale.sv
// Divides pclk by twelve into a one-cycle tick for timer mode.
// Assumes pclk stands in for the oscillator.
`timescale 1ns/10ps
module tmtwo_prescale (
	input wire logic pclk,
	input wire logic presetn,
	output logic tick
);
	logic [3:0] div;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			div <= 4'h0;
		end else if (div == tmtwo_pkg::TICK_LAST) begin
			div <= 4'h0;
		end else begin
			div <= div + 4'h1;
		end
	end
	assign tick = (div == tmtwo_pkg::TICK_LAST);
endmodule : tmtwo_prescale

// File: design/tmtwo_timer.sv
// Third 16-bit timer/counter with capture, auto-reload and baud generator modes.
// Assumes APB master on pclk; count and trigger pins are asynchronous.
`timescale 1ns/10ps
module tmtwo_timer (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic count_input_pin,
	input wire logic external_trigger_pin,
	input wire logic other_timer_overflow,
	output logic serial_rx_clock,
	output logic serial_tx_clock,
	output logic timer_interrupt
);
	logic [7:0] timer_two_control;
	logic [15:0] count;
	logic [15:0] reload;
	logic [15:0] next_count;
	logic ovf_pulse;
	logic tick;
	logic count_fall;
	logic trig_fall;
	logic step;
	logic trig_event;
	logic baud_sel;
	logic wr_en;
	logic set_ovf;
	logic set_exf;
	tmtwo_pkg::tmtwo_mode_t mode;

	tmtwo_prescale u_prescale (
		.pclk(pclk),
		.presetn(presetn),
		.tick(tick)
	);
	tmtwo_fall_detect u_count_edge (
		.pclk(pclk),
		.presetn(presetn),
		.pin(count_input_pin),
		.fall(count_fall)
	);
	tmtwo_fall_detect u_trig_edge (
		.pclk(pclk),
		.presetn(presetn),
		.pin(external_trigger_pin),
		.fall(trig_fall)
	);

	assign wr_en = psel & penable & pwrite;
	assign pready = 1'b1;
	assign baud_sel = timer_two_control[tmtwo_pkg::BIT_RCLK] |
		timer_two_control[tmtwo_pkg::BIT_TX_SEL];

	always_comb begin
		if (!timer_two_control[tmtwo_pkg::BIT_RUN]) begin
			mode = tmtwo_pkg::TMTWO_OFF;
		end else if (baud_sel) begin
			mode = tmtwo_pkg::TMTWO_BAUD;
		end else if (timer_two_control[tmtwo_pkg::BIT_CPRL]) begin
			mode = tmtwo_pkg::TMTWO_CAPTURE;
		end else begin
			mode = tmtwo_pkg::TMTWO_RELOAD;
		end
	end

	assign step = (mode != tmtwo_pkg::TMTWO_OFF) &&
		(timer_two_control[tmtwo_pkg::BIT_CT] ? count_fall : tick);
	assign ovf_pulse = step && (count == 16'hFFFF);
	assign trig_event = trig_fall && timer_two_control[tmtwo_pkg::BIT_EXEN] && !baud_sel &&
		(mode != tmtwo_pkg::TMTWO_OFF);
	// no overflow flag in baud mode
	assign set_ovf = ovf_pulse && !baud_sel;
	assign set_exf = trig_event;

	// Next count value
	always_comb begin
		next_count = count;
		if (step) begin
			next_count = count + 16'h0001;
		end
		if (ovf_pulse && mode != tmtwo_pkg::TMTWO_CAPTURE) begin
			next_count = reload;
		end
		if (trig_event && mode == tmtwo_pkg::TMTWO_RELOAD) begin
			next_count = reload;
		end
	end

	// software access to count bytes; hardware step loses to a write
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			count <= tmtwo_pkg::COUNT_RESET;
		end else if (wr_en && paddr == tmtwo_pkg::ADDR_COUNT_LOW) begin
			count <= {count[15:8], pwdata[7:0]};
		end else if (wr_en && paddr == tmtwo_pkg::ADDR_COUNT_HIGH) begin
			count <= {pwdata[7:0], count[7:0]};
		end else begin
			count <= next_count;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			reload <= tmtwo_pkg::RELOAD_RESET;
		end else if (trig_event && mode == tmtwo_pkg::TMTWO_CAPTURE) begin
			reload <= count;
		end else if (wr_en && paddr == tmtwo_pkg::ADDR_RELOAD_LOW) begin
			reload <= {reload[15:8], pwdata[7:0]};
		end else if (wr_en && paddr == tmtwo_pkg::ADDR_RELOAD_HIGH) begin
			reload <= {pwdata[7:0], reload[7:0]};
		end
	end

	// control layout; flags set wins over software clear
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			timer_two_control <= tmtwo_pkg::CONTROL_RESET;
		end else begin
			if (wr_en && paddr == tmtwo_pkg::ADDR_CONTROL) begin
				timer_two_control <= pwdata[7:0];
			end
			if (set_ovf) begin
				timer_two_control[tmtwo_pkg::BIT_OVF] <= 1'b1;
			end
			if (set_exf) begin
				timer_two_control[tmtwo_pkg::BIT_EXF] <= 1'b1;
			end
		end
	end

	assign timer_interrupt = timer_two_control[tmtwo_pkg::BIT_OVF] |
		timer_two_control[tmtwo_pkg::BIT_EXF];

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			serial_rx_clock <= 1'b0;
			serial_tx_clock <= 1'b0;
		end else begin
			serial_rx_clock <= timer_two_control[tmtwo_pkg::BIT_RCLK] ? ovf_pulse :
				other_timer_overflow;
			serial_tx_clock <= timer_two_control[tmtwo_pkg::BIT_TX_SEL] ? ovf_pulse :
				other_timer_overflow;
		end
	end

	// Read data registered in the setup cycle; unmapped reads zero, no error
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h0000_0000;
		end else if (psel && !penable && !pwrite) begin
			if (paddr == tmtwo_pkg::ADDR_CONTROL) begin
				prdata <= {24'h000000, timer_two_control};
			end else if (paddr == tmtwo_pkg::ADDR_COUNT_LOW) begin
				prdata <= {24'h000000, count[7:0]};
			end else if (paddr == tmtwo_pkg::ADDR_COUNT_HIGH) begin
				prdata <= {24'h000000, count[15:8]};
			end else if (paddr == tmtwo_pkg::ADDR_RELOAD_LOW) begin
				prdata <= {24'h000000, reload[7:0]};
			end else if (paddr == tmtwo_pkg::ADDR_RELOAD_HIGH) begin
				prdata <= {24'h000000, reload[15:8]};
			end else if (paddr == tmtwo_pkg::ADDR_SERIAL_TICK) begin
				prdata <= {28'h0000000, mode};
			end else begin
				prdata <= tmtwo_pkg::UNMAPPED_READ;
			end
		end
	end
	assign pslverr = 1'b0;

	// no overflow flag set in baud mode
	ovf_baud_a: assert property (@(posedge pclk) disable iff (!presetn)
		(baud_sel && !(wr_en && paddr == tmtwo_pkg::ADDR_CONTROL) &&
		!timer_two_control[tmtwo_pkg::BIT_OVF]) |=> !timer_two_control[tmtwo_pkg::BIT_OVF])
		else $error("overflow flag set in baud mode");
	ovf_set_a: assert property (@(posedge pclk) disable iff (!presetn)
		(mode == tmtwo_pkg::TMTWO_CAPTURE && ovf_pulse) |=> timer_two_control[tmtwo_pkg::BIT_OVF])
		else $error("overflow flag missed");
	reload_load_a: assert property (@(posedge pclk) disable iff (!presetn)
		(mode == tmtwo_pkg::TMTWO_RELOAD && ovf_pulse && !wr_en) |=> count == $past(reload))
		else $error("reload not applied");
	capture_copy_a: assert property (@(posedge pclk) disable iff (!presetn)
		(mode == tmtwo_pkg::TMTWO_CAPTURE && trig_event) |=>
		(reload == $past(count) && timer_two_control[tmtwo_pkg::BIT_EXF]))
		else $error("capture failed");
	trig_ignore_a: assert property (@(posedge pclk) disable iff (!presetn)
		(trig_fall && (!timer_two_control[tmtwo_pkg::BIT_EXEN] || baud_sel) && !wr_en &&
		!timer_two_control[tmtwo_pkg::BIT_EXF]) |=> !timer_two_control[tmtwo_pkg::BIT_EXF])
		else $error("trigger not blocked");
	run_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
		(!timer_two_control[tmtwo_pkg::BIT_RUN] && !wr_en) |=> $stable(count))
		else $error("count moved while stopped");
	// no second timer step within eight clocks of a timer step
	timer_rate_a: assert property (@(posedge pclk) disable iff (!presetn)
		(step && !timer_two_control[tmtwo_pkg::BIT_CT]) |=>
		(!(step && !timer_two_control[tmtwo_pkg::BIT_CT])) [*8])
		else $error("timer step too frequent");
	baud_reload_a: assert property (@(posedge pclk) disable iff (!presetn)
		(mode == tmtwo_pkg::TMTWO_BAUD && ovf_pulse && !wr_en) |=> count == $past(reload))
		else $error("baud reload missing");
	tx_route_a: assert property (@(posedge pclk) disable iff (!presetn)
		(timer_two_control[tmtwo_pkg::BIT_TX_SEL] && ovf_pulse) |=> serial_tx_clock)
		else $error("transmit clock not routed");
	tx_other_a: assert property (@(posedge pclk) disable iff (!presetn)
		(!timer_two_control[tmtwo_pkg::BIT_TX_SEL] && other_timer_overflow) |=> serial_tx_clock)
		else $error("other timer not routed to transmit clock");
	rx_route_a: assert property (@(posedge pclk) disable iff (!presetn)
		(timer_two_control[tmtwo_pkg::BIT_RCLK] && ovf_pulse) |=> serial_rx_clock)
		else $error("receive clock not routed");
	rx_other_a: assert property (@(posedge pclk) disable iff (!presetn)
		(!timer_two_control[tmtwo_pkg::BIT_RCLK] && other_timer_overflow) |=> serial_rx_clock)
		else $error("other timer not routed to receive clock");
	tick_period_a: assert property (@(posedge pclk) disable iff (!presetn)
		tick |-> ##12 tick)
		else $error("prescaler tick period wrong");
	trig_reload_a: assert property (@(posedge pclk) disable iff (!presetn)
		(mode == tmtwo_pkg::TMTWO_RELOAD && trig_event && !wr_en) |=>
		(count == $past(reload) && timer_two_control[tmtwo_pkg::BIT_EXF]))
		else $error("trigger reload failed");
	reload_flag_a: assert property (@(posedge pclk) disable iff (!presetn)
		(mode == tmtwo_pkg::TMTWO_RELOAD && ovf_pulse) |=> timer_two_control[tmtwo_pkg::BIT_OVF])
		else $error("overflow flag missed in reload mode");
	ovf_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
		(timer_two_control[tmtwo_pkg::BIT_OVF] && !(wr_en && paddr == tmtwo_pkg::ADDR_CONTROL))
		|=> timer_two_control[tmtwo_pkg::BIT_OVF])
		else $error("overflow flag dropped");
	exf_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
		(timer_two_control[tmtwo_pkg::BIT_EXF] && !(wr_en && paddr == tmtwo_pkg::ADDR_CONTROL))
		|=> timer_two_control[tmtwo_pkg::BIT_EXF])
		else $error("external flag dropped");
	capture_wrap_a: assert property (@(posedge pclk) disable iff (!presetn)
		(mode == tmtwo_pkg::TMTWO_CAPTURE && ovf_pulse && !wr_en) |=> count == 16'h0000)
		else $error("capture mode did not wrap to zero");
	count_step_a: assert property (@(posedge pclk) disable iff (!presetn)
		(step && !ovf_pulse && !trig_event && !wr_en) |=> count == $past(count) + 16'h0001)
		else $error("count step wrong");
	count_write_a: assert property (@(posedge pclk) disable iff (!presetn)
		(wr_en && paddr == tmtwo_pkg::ADDR_COUNT_LOW) |=> count[7:0] == $past(pwdata[7:0]))
		else $error("count low byte write lost");
	reload_write_a: assert property (@(posedge pclk) disable iff (!presetn)
		(wr_en && paddr == tmtwo_pkg::ADDR_RELOAD_HIGH && !trig_event) |=>
		reload[15:8] == $past(pwdata[7:0]))
		else $error("reload high byte write lost");
	ctl_write_a: assert property (@(posedge pclk) disable iff (!presetn)
		(wr_en && paddr == tmtwo_pkg::ADDR_CONTROL) |=>
		timer_two_control[tmtwo_pkg::BIT_RCLK:0] == $past(pwdata[tmtwo_pkg::BIT_RCLK:0]))
		else $error("control write lost");
endmodule : tmtwo_timer

// File: sim/testbench.sv
// Self-checking bench for the timer: APB master, one task per scenario.
// Assumes an APB slave on pclk and the partner model for the pins.
`timescale 1ns/10ps
module testbench;
	logic pclk;
	logic presetn;
	logic psel;
	logic penable;
	logic pwrite;
	logic [7:0] paddr;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic pready, pslverr, cnt_pin, trg_pin, oth_ovf, rx_clk, tx_clk, irq;
	int n_mismatch = 0;
	int cmp_count = 0;
	logic [31:0] q;
	logic err;
	tmtwo_timer u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .count_input_pin(cnt_pin), .external_trigger_pin(trg_pin),
		.other_timer_overflow(oth_ovf), .serial_rx_clock(rx_clk), .serial_tx_clock(tx_clk),
		.timer_interrupt(irq));
	tmtwo_serial_model u_part (.pclk(pclk), .serial_rx_clock(rx_clk),
		.serial_tx_clock(tx_clk), .count_input_pin(cnt_pin),
		.external_trigger_pin(trg_pin), .other_timer_overflow(oth_ovf));
	initial begin
		pclk = 1'b0;
		forever #50 pclk = ~pclk;
	end
	task end_sim();
		$display("checks %0d mismatches %0d", cmp_count, n_mismatch);
		if (n_mismatch == 0 && cmp_count > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask : end_sim
	task chk(input string name, input logic [31:0] exp, input logic [31:0] got);
		cmp_count++;
		if (got !== exp) begin
			n_mismatch++;
			$display("[ERR] %s expected %h seen %h", name, exp, got);
		end
	endtask : chk
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (!(pready === 1'b1) && n < 20);
		q = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (pready !== 1'b1) begin
			n_mismatch++;
			end_sim();
		end
	endtask : apb
	task rdchk(input string name, input logic [7:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0000_0000);
		chk(name, e, q);
		chk("slverr", 0, err);
	endtask : rdchk
	task t_reset();
		for (int a = 0; a <= 16; a += 4) rdchk("reg", 8'(a), 32'h0000_0000);
		rdchk("mode", 8'h14, 32'h0000_0001);
		apb(1'b1, 8'h20, 32'h0000_00FF);
		rdchk("unmapped", 8'h20, 32'h0000_0000);
		apb(1'b1, 8'h00, 32'h0000_0039);
		rdchk("ctl", 8'h00, 32'h0000_0039);
		rdchk("mode", 8'h14, 32'h0000_0001);
		$display("test reset done");
	endtask : t_reset
	task t_reload();
		apb(1'b1, 8'h0C, 32'h0000_00F0);
		apb(1'b1, 8'h10, 32'h0000_00FF);
		apb(1'b1, 8'h04, 32'h0000_00FE);
		apb(1'b1, 8'h08, 32'h0000_00FF);
		apb(1'b1, 8'h00, 32'h0000_0006);
		rdchk("mode", 8'h14, 32'h0000_0002);
		repeat (40) @(posedge pclk);
		rdchk("cnt_lo", 8'h04, 32'h0000_00FE);
		u_part.fall(1'b0);
		rdchk("cnt_lo", 8'h04, 32'h0000_00FF);
		u_part.fall(1'b0);
		rdchk("cnt_lo", 8'h04, 32'h0000_00F0);
		rdchk("cnt_hi", 8'h08, 32'h0000_00FF);
		rdchk("ctl", 8'h00, 32'h0000_0086);
		chk("irq", 1, irq);
		repeat (30) @(posedge pclk);
		rdchk("ctl", 8'h00, 32'h0000_0086);
		apb(1'b1, 8'h04, 32'h0000_0055);
		apb(1'b1, 8'h00, 32'h0000_000E);
		u_part.fall(1'b1);
		rdchk("trg_lo", 8'h04, 32'h0000_00F0);
		rdchk("trg_ctl", 8'h00, 32'h0000_004E);
		apb(1'b1, 8'h00, 32'h0000_0000);
		u_part.fall(1'b0);
		rdchk("hold", 8'h04, 32'h0000_00F0);
		chk("irq", 0, irq);
		$display("test reload done");
	endtask : t_reload
	task t_capture();
		apb(1'b1, 8'h04, 32'h0000_0034);
		apb(1'b1, 8'h08, 32'h0000_0012);
		apb(1'b1, 8'h00, 32'h0000_0007);
		u_part.fall(1'b1);
		rdchk("noexen", 8'h00, 32'h0000_0007);
		apb(1'b1, 8'h00, 32'h0000_000F);
		rdchk("mode", 8'h14, 32'h0000_0004);
		u_part.fall(1'b1);
		rdchk("cap_lo", 8'h0C, 32'h0000_0034);
		rdchk("cap_hi", 8'h10, 32'h0000_0012);
		rdchk("ctl", 8'h00, 32'h0000_004F);
		chk("irq", 1, irq);
		apb(1'b1, 8'h04, 32'h0000_00FF);
		apb(1'b1, 8'h08, 32'h0000_00FF);
		u_part.fall(1'b0);
		rdchk("ctl", 8'h00, 32'h0000_00CF);
		rdchk("wrap", 8'h08, 32'h0000_0000);
		$display("test capture done");
	endtask : t_capture
	task t_baud();
		int r0, t0;
		apb(1'b1, 8'h00, 32'h0000_0000);
		apb(1'b1, 8'h0C, 32'h0000_00CD);
		apb(1'b1, 8'h10, 32'h0000_00AB);
		apb(1'b1, 8'h04, 32'h0000_00FF);
		apb(1'b1, 8'h08, 32'h0000_00FF);
		apb(1'b1, 8'h00, 32'h0000_002F);
		rdchk("mode", 8'h14, 32'h0000_0008);
		r0 = u_part.rx_ticks;
		t0 = u_part.tx_ticks;
		u_part.fall(1'b0);
		chk("rx", r0 + 1, u_part.rx_ticks);
		rdchk("rld", 8'h08, 32'h0000_00AB);
		rdchk("noovf", 8'h00, 32'h0000_002F);
		u_part.fall(1'b1);
		rdchk("noext", 8'h00, 32'h0000_002F);
		rdchk("nocap", 8'h04, 32'h0000_00CD);
		u_part.other_ovf();
		chk("tx", t0 + 1, u_part.tx_ticks);
		chk("rx2", r0 + 1, u_part.rx_ticks);
		apb(1'b1, 8'h04, 32'h0000_00FF);
		apb(1'b1, 8'h08, 32'h0000_00FF);
		apb(1'b1, 8'h00, 32'h0000_0016);
		u_part.fall(1'b0);
		chk("tx2", t0 + 2, u_part.tx_ticks);
		rdchk("tx_ovf", 8'h00, 32'h0000_0016);
		u_part.other_ovf();
		chk("rx3", r0 + 2, u_part.rx_ticks);
		chk("tx3", t0 + 2, u_part.tx_ticks);
		$display("test baud done");
	endtask : t_baud
	task t_timer();
		apb(1'b1, 8'h00, 32'h0000_0000);
		apb(1'b1, 8'h04, 32'h0000_0000);
		apb(1'b1, 8'h08, 32'h0000_0000);
		apb(1'b1, 8'h00, 32'h0000_0004);
		repeat (120) @(posedge pclk);
		apb(1'b1, 8'h00, 32'h0000_0000);
		apb(1'b0, 8'h04, 32'h0000_0000);
		chk("ticks", 1, q >= 10 && q <= 11);
		rdchk("ticks_hi", 8'h08, 32'h0000_0000);
		apb(1'b1, 8'h04, 32'h0000_0077);
		repeat (50) @(posedge pclk);
		rdchk("held", 8'h04, 32'h0000_0077);
		$display("test timer done");
	endtask : t_timer
	task t_rst2();
		apb(1'b1, 8'h00, 32'h0000_00C4);
		@(posedge pclk);
		presetn <= 1'b0;
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		rdchk("rst_ctl", 8'h00, 32'h0000_0000);
		chk("rst_irq", 0, irq);
		rdchk("rst_cnt", 8'h04, 32'h0000_0000);
		rdchk("rst_rld", 8'h10, 32'h0000_0000);
		rdchk("rst_mode", 8'h14, 32'h0000_0001);
		$display("test midreset done");
	endtask : t_rst2
	initial begin
		presetn <= 1'b0;
		psel <= 1'b0;
		penable <= 1'b0;
		pwrite <= 1'b0;
		paddr <= 8'h00;
		pwdata <= 32'h0000_0000;
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
		t_reset();
		t_reload();
		t_capture();
		t_baud();
		t_timer();
		t_rst2();
		end_sim();
	end
endmodule : testbench

// File: sim/tmtwo_serial_model.sv
// Far side of the timer: serial clock sink plus count, trigger and other-timer sources.
// Assumes count and trigger pins idle high, other-timer overflow idles low; every change lands just after a rising pclk edge.
`timescale 1ns/10ps
module tmtwo_serial_model (
	input wire logic pclk,
	input wire logic serial_rx_clock,
	input wire logic serial_tx_clock,
	output logic count_input_pin,
	output logic external_trigger_pin,
	output logic other_timer_overflow
);
	int rx_ticks = 0;
	int tx_ticks = 0;
	initial begin
		count_input_pin = 1'b1;
		external_trigger_pin = 1'b1;
		other_timer_overflow = 1'b0;
	end
	always @(posedge pclk) begin
		if (serial_rx_clock === 1'b1) rx_ticks <= rx_ticks + 1;
		if (serial_tx_clock === 1'b1) tx_ticks <= tx_ticks + 1;
	end
	// Low for four cycles so the two-stage synchroniser sees it
	task fall(input bit trig);
		@(posedge pclk);
		if (trig) external_trigger_pin <= 1'b0;
		else count_input_pin <= 1'b0;
		repeat (4) @(posedge pclk);
		external_trigger_pin <= 1'b1;
		count_input_pin <= 1'b1;
		repeat (4) @(posedge pclk);
	endtask : fall
	task other_ovf();
		@(posedge pclk);
		other_timer_overflow <= 1'b1;
		@(posedge pclk);
		other_timer_overflow <= 1'b0;
		repeat (3) @(posedge pclk);
	endtask : other_ovf
endmodule : tmtwo_serial_model
